//--- hw/strap_gpio_misc_control.sv
// Miscellaneous pin control: GPIO, straps, EEPROM and management pins, scan pin
`timescale 1ns/100ps
`default_nettype none
`include "misc_pins_regs.svh"
module strap_gpio_misc_control #(
   parameter int       GPIO_W    = 8,
   parameter int       NUM_PORTS = 3,
   parameter bit       MGMT_IMPL = 1'b1
) (
   // Clock, reset, enable
   input  wire logic                 SYS_CLK,
   input  wire logic                 RSTN,
   input  wire logic                 CE,
   // AHB-Lite slave
   input  wire logic                 HSEL,
   input  wire logic [31:0]          HADDR,
   input  wire logic [1:0]           HTRANS,
   input  wire logic                 HWRITE,
   input  wire logic [2:0]           HSIZE,
   input  wire logic [31:0]          HWDATA,
   input  wire logic                 HREADY,
   output logic                      HREADYOUT,
   output logic      [31:0]          HRDATA,
   output logic                      HRESP,
   // General-purpose pins
   input  wire logic [GPIO_W-1:0]    GPIO_I,
   output logic      [GPIO_W-1:0]    GPIO_O,
   output logic      [GPIO_W-1:0]    GPIO_OE,
   // EEPROM pins
   output logic                      EEPROM_SERIAL_CLOCK,
   input  wire logic                 EEPROM_SERIAL_DATA_I,
   output logic                      EEPROM_SERIAL_DATA_O,
   output logic                      EEPROM_SERIAL_DATA_OE,
   // Management bus pins
   input  wire logic                 MGMT_BUS_CLOCK_PIN,
   input  wire logic                 MGMT_BUS_DATA_PIN_I,
   output logic                      MGMT_BUS_DATA_PIN_O,
   output logic                      MGMT_BUS_DATA_PIN_OE,
   // Strap and test pins
   input  wire logic                 POWER_SAVING_STRAP,
   input  wire logic                 DEBUG_MODE_ENABLE_STRAP_N,
   input  wire logic                 PORT_STATUS_OUTPUT_ENABLE,
   input  wire logic                 MFG_TEST_MODE,
   input  wire logic                 FULL_SCAN_I,
   output logic                      FULL_SCAN_O,
   output logic                      FULL_SCAN_OE,
   // Port status
   input  wire logic [NUM_PORTS-1:0] PORT_COND,
   output logic      [NUM_PORTS-1:0] PORT_STATUS,
   // Core-side results
   output logic                      POWER_SAVE_MODE,
   output logic                      DEBUG_MODE,
   output logic      [4:0]           DEBUG_SELECT,
   output logic      [2:0]           MGMT_ADDR,
   output logic                      SCAN_ACTIVE
);
   // ----------------------------------------
   // Synchronised pin inputs
   // ----------------------------------------
   localparam int SW = GPIO_W + 8;
   localparam int I_EE = GPIO_W;
   localparam int I_MCLK = GPIO_W + 1;
   localparam int I_MDAT = GPIO_W + 2;
   localparam int I_PWR = GPIO_W + 3;
   localparam int I_DBGN = GPIO_W + 4;
   localparam int I_PSE = GPIO_W + 5;
   localparam int I_MFG = GPIO_W + 6;
   localparam int I_SCAN = GPIO_W + 7;

   logic [SW-1:0] pin_q;

   generate
      if (GPIO_W != 8 || NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_chk
         $error("strap_gpio_misc_control: unsupported parameters");
      end
   endgenerate

   // Every pin level except PORT_COND passes two flops
   pin_sync #(
      .W (SW)
   ) u_sync (
      .clk  (SYS_CLK),
      .rstn (RSTN),
      .ce   (CE),
      .d    ({FULL_SCAN_I, MFG_TEST_MODE, PORT_STATUS_OUTPUT_ENABLE,
              DEBUG_MODE_ENABLE_STRAP_N, POWER_SAVING_STRAP,
              MGMT_BUS_DATA_PIN_I, MGMT_BUS_CLOCK_PIN,
              EEPROM_SERIAL_DATA_I, GPIO_I}),
      .q    (pin_q)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic                          wr_pend;
      logic [7:0]                    waddr;
      logic [GPIO_W-1:0]             gpio_out;
      logic [GPIO_W-1:0]             gpio_oe_reg;
      logic [3:0]                    ee_ctl;
      logic                          mgmt_low;
      misc_pins_pkg::cap_state_t     cap;
      logic                          pwr;
      logic                          dbg;
      logic [4:0]                    dsel;
      logic [2:0]                    addr;
      logic                          hready;
      logic [31:0]                   hrdata;
      logic [GPIO_W-1:0]             gpio_o;
      logic [GPIO_W-1:0]             gpio_oe;
      logic                          ee_clk;
      logic                          ee_o;
      logic                          ee_oe;
      logic                          m_oe;
      logic                          scan_oe;
      logic                          scan_act;
      logic [NUM_PORTS-1:0]          pstat;
   } state_t;

   state_t st;
   state_t n;
   logic   addr_ph;
   logic   gpio_mask_dbg;
   logic [31:0] rmux;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      n = st;
      addr_ph = HSEL && HTRANS[1] && HREADY;
      // Bus write lands in its data phase
      if (st.wr_pend) begin
         case (st.waddr)
            `MP_GPIO_OUT_OFS: n.gpio_out    = HWDATA[GPIO_W-1:0];
            `MP_GPIO_OE_OFS:  n.gpio_oe_reg = HWDATA[GPIO_W-1:0];
            `MP_EE_CTL_OFS:   n.ee_ctl      = HWDATA[3:0];
            `MP_MGMT_CTL_OFS: n.mgmt_low    = HWDATA[`MP_MGMT_LOW_BIT];
            default: ;
         endcase
      end
      n.wr_pend = addr_ph && HWRITE && (HSIZE == 3'h2);
      n.waddr   = HADDR[7:0];
      n.hready  = 1'b1;
      // Strap capture waits for the synchroniser to fill
      case (st.cap)
         misc_pins_pkg::CAP_WAIT:  n.cap = misc_pins_pkg::CAP_FILL1;
         misc_pins_pkg::CAP_FILL1: n.cap = misc_pins_pkg::CAP_FILL2;
         misc_pins_pkg::CAP_FILL2: begin
            n.cap  = misc_pins_pkg::CAP_HELD;
            n.pwr  = pin_q[I_PWR];
            n.dbg  = !pin_q[I_DBGN];
            n.dsel = pin_q[4:0];
            n.addr = MGMT_IMPL ? pin_q[7:5] : 3'h0;
         end
         misc_pins_pkg::CAP_HELD:  n.cap = misc_pins_pkg::CAP_HELD;
         default:                  n.cap = misc_pins_pkg::CAP_WAIT;
      endcase
      // GPIO drive; debug mode takes the low five pins
      gpio_mask_dbg = n.dbg;
      n.gpio_o  = n.gpio_out;
      n.gpio_oe = n.gpio_oe_reg;
      if (gpio_mask_dbg) begin
         n.gpio_oe[4:0] = 5'h00;
      end
      // EEPROM clock and data
      n.ee_clk = n.ee_ctl[`MP_EE_CLK_BIT];
      if (n.ee_ctl[`MP_EE_ACTIVE_BIT]) begin
         n.ee_o  = n.ee_ctl[`MP_EE_DATA_BIT];
         n.ee_oe = !n.ee_ctl[`MP_EE_RELEASE_BIT];
      end else begin
         n.ee_o  = 1'b1;
         n.ee_oe = 1'b1;
      end
      // Management data is open drain, driven only to send a low
      n.m_oe = n.mgmt_low;
      // Scan pin driven low unless in manufacturing test
      n.scan_oe  = !pin_q[I_MFG];
      n.scan_act = pin_q[I_MFG] && pin_q[I_SCAN];
      // Port status, gated by the enable pin in debug mode
      if (n.dbg && !pin_q[I_PSE]) begin
         n.pstat = '0;
      end else begin
         n.pstat = PORT_COND;
      end
      // Read mux sees writes that land this cycle
      rmux = 32'h0000_0000;
      case (HADDR[7:0])
         `MP_GPIO_OUT_OFS: rmux[GPIO_W-1:0] = n.gpio_out;
         `MP_GPIO_OE_OFS:  rmux[GPIO_W-1:0] = n.gpio_oe_reg;
         `MP_GPIO_IN_OFS:  rmux[GPIO_W-1:0] = pin_q[GPIO_W-1:0];
         `MP_STRAP_OFS: begin
            rmux[`MP_ST_PWR_BIT]                   = n.pwr;
            rmux[`MP_ST_DBG_BIT]                   = n.dbg;
            rmux[`MP_ST_ADDR_LSB+2:`MP_ST_ADDR_LSB] = n.addr;
            rmux[`MP_ST_SEL_LSB+4:`MP_ST_SEL_LSB]   = n.dsel;
            rmux[`MP_ST_HELD_BIT] = (n.cap == misc_pins_pkg::CAP_HELD);
         end
         `MP_EE_CTL_OFS: begin
            rmux[3:0]            = n.ee_ctl;
            rmux[`MP_EE_IN_BIT]  = pin_q[I_EE];
         end
         `MP_MGMT_CTL_OFS: begin
            rmux[`MP_MGMT_LOW_BIT] = n.mgmt_low;
            rmux[`MP_MGMT_CLK_BIT] = pin_q[I_MCLK];
            rmux[`MP_MGMT_IN_BIT]  = pin_q[I_MDAT];
         end
         `MP_PORT_OFS: begin
            rmux[NUM_PORTS-1:0] = n.pstat;
            rmux[NUM_PORTS]     = pin_q[I_PSE];
         end
         default: rmux = 32'h0000_0000;
      endcase
      if (addr_ph && !HWRITE) begin
         n.hrdata = rmux;
      end
   end

   // State register
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st             <= '0;
         st.cap         <= misc_pins_pkg::CAP_WAIT;
         st.gpio_out    <= `MP_GPIO_OUT_RST;
         st.gpio_oe_reg <= `MP_GPIO_OE_RST;
         st.ee_ctl      <= `MP_EE_CTL_RST;
         st.hready      <= 1'b1;
         st.ee_o        <= 1'b1;
         st.ee_oe       <= 1'b1;
         st.scan_oe     <= 1'b1;
      end else if (CE) begin
         st <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign HREADYOUT             = st.hready;
   assign HRDATA                = st.hrdata;
   assign HRESP                 = 1'b0;
   assign GPIO_O                = st.gpio_o;
   assign GPIO_OE               = st.gpio_oe;
   assign EEPROM_SERIAL_CLOCK   = st.ee_clk;
   assign EEPROM_SERIAL_DATA_O  = st.ee_o;
   assign EEPROM_SERIAL_DATA_OE = st.ee_oe;
   assign MGMT_BUS_DATA_PIN_O   = 1'b0;
   assign MGMT_BUS_DATA_PIN_OE  = st.m_oe;
   assign FULL_SCAN_O           = 1'b0;
   assign FULL_SCAN_OE          = st.scan_oe;
   assign PORT_STATUS           = st.pstat;
   assign POWER_SAVE_MODE       = st.pwr;
   assign DEBUG_MODE            = st.dbg;
   assign DEBUG_SELECT          = st.dsel;
   assign MGMT_ADDR             = st.addr;
   assign SCAN_ACTIVE           = st.scan_act;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);

   logic held;
   assign held = (st.cap == misc_pins_pkg::CAP_HELD);

   a_gpio_oe_write: assert property (CE && st.wr_pend && st.waddr == `MP_GPIO_OE_OFS ##1 !st.dbg
      |-> GPIO_OE[7:5] == $past(HWDATA[7:5])) else $error("GPIO enable not taken");
   a_mgmt_addr_cap: assert property (CE && st.cap == misc_pins_pkg::CAP_FILL2
      |=> MGMT_ADDR == (MGMT_IMPL ? $past(pin_q[7:5]) : 3'h0)) else $error("Address strap wrong");
   a_debug_pins_in: assert property (held && DEBUG_MODE |-> GPIO_OE[4:0] == 5'h00)
      else $error("GPIO 4..0 driven in debug mode");
   a_power_strap_hi: assert property (CE && st.cap == misc_pins_pkg::CAP_FILL2 && pin_q[I_PWR]
      |=> POWER_SAVE_MODE) else $error("Power saving not enabled");
   a_power_strap_lo: assert property (CE && st.cap == misc_pins_pkg::CAP_FILL2 && !pin_q[I_PWR]
      |=> !POWER_SAVE_MODE) else $error("Power saving wrongly enabled");
   a_scan_drive_low: assert property (CE && !pin_q[I_MFG] |=> FULL_SCAN_OE && !FULL_SCAN_O)
      else $error("Scan pin not driven low");
   a_scan_released: assert property (CE && pin_q[I_MFG] |=> !FULL_SCAN_OE)
      else $error("Scan pin not released");
   a_ee_idle_high: assert property (CE && st.wr_pend && st.waddr == `MP_EE_CTL_OFS
      && !HWDATA[`MP_EE_ACTIVE_BIT] |=> EEPROM_SERIAL_DATA_O && EEPROM_SERIAL_DATA_OE)
      else $error("EEPROM data not held high");
   a_ee_clock_out: assert property (CE && st.wr_pend && st.waddr == `MP_EE_CTL_OFS
      |=> EEPROM_SERIAL_CLOCK == $past(HWDATA[`MP_EE_CLK_BIT])) else $error("EEPROM clock wrong");
   a_port_gate: assert property (CE && st.dbg && !pin_q[I_PSE] |=> PORT_STATUS == '0)
      else $error("Port status not gated");
   a_debug_strap: assert property (CE && st.cap == misc_pins_pkg::CAP_FILL2
      |=> DEBUG_MODE == !$past(pin_q[I_DBGN])) else $error("Debug strap wrong");
   a_strap_hold: assert property (held && $past(held)
      |-> $stable(POWER_SAVE_MODE) && $stable(MGMT_ADDR) && $stable(DEBUG_SELECT))
      else $error("Strap levels changed");

   c_oe_write: cover property (st.wr_pend && st.waddr == `MP_GPIO_OE_OFS);
   c_debug_held: cover property (held && DEBUG_MODE);
   c_mfg_test: cover property (SCAN_ACTIVE);
   c_ee_read: cover property (st.ee_ctl[`MP_EE_ACTIVE_BIT] && !EEPROM_SERIAL_DATA_OE);
endmodule // strap_gpio_misc_control
`default_nettype wire

//--- hw/misc_pins_regs.svh
// Register offsets, field positions and reset values of the miscellaneous pin block
`ifndef MISC_PINS_REGS_SVH
`define MISC_PINS_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MP_GPIO_OUT_OFS   8'h00
`define MP_GPIO_OE_OFS    8'h04
`define MP_GPIO_IN_OFS    8'h08
`define MP_STRAP_OFS      8'h0C
`define MP_EE_CTL_OFS     8'h10
`define MP_MGMT_CTL_OFS   8'h14
`define MP_PORT_OFS       8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MP_EE_CLK_BIT     0
`define MP_EE_DATA_BIT    1
`define MP_EE_ACTIVE_BIT  2
`define MP_EE_RELEASE_BIT 3
`define MP_EE_IN_BIT      4
`define MP_MGMT_LOW_BIT   0
`define MP_MGMT_CLK_BIT   1
`define MP_MGMT_IN_BIT    2
`define MP_ST_PWR_BIT     0
`define MP_ST_DBG_BIT     1
`define MP_ST_ADDR_LSB    2
`define MP_ST_SEL_LSB     5
`define MP_ST_HELD_BIT    10
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MP_GPIO_OUT_RST   8'h00
`define MP_GPIO_OE_RST    8'h00
`define MP_EE_CTL_RST     4'h0
`endif

//--- hw/misc_pins_pkg.sv
// Types shared by the miscellaneous pin block
package misc_pins_pkg;
   // Strap capture sequence after reset release
   typedef enum logic [3:0] {
      CAP_WAIT  = 4'b0001,
      CAP_FILL1 = 4'b0010,
      CAP_FILL2 = 4'b0100,
      CAP_HELD  = 4'b1000
   } cap_state_t;
endpackage

//--- hw/pin_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t st;
   sync_t next_st;

   generate
      if (W < 1) begin : g_chk
         $error("pin_sync width must be positive");
      end
   endgenerate

   // Second stage reads only the first
   always_comb begin
      next_st    = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // State register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule // pin_sync
`default_nettype wire

//--- tb/board_model.sv
// Board-side partner: strap resistors, serial EEPROM and management bus host
`timescale 1ns/100ps
`default_nettype none
module board_model (
   // Clock
   input  wire logic       clk,
   // Bench controls
   input  wire logic [7:0] level,
   input  wire logic       clk_run,
   input  wire logic       pull_low,
   input  wire logic       rep_en,
   input  wire logic       rep_bit,
   // Device drivers
   input  wire logic [7:0] gpio_o,
   input  wire logic [7:0] gpio_oe,
   input  wire logic       ee_o,
   input  wire logic       ee_oe,
   input  wire logic       md_o,
   input  wire logic       md_oe,
   // Pin levels
   output logic      [7:0] gpio_i,
   output logic            ee_d,
   output logic            mclk,
   output logic            md
);
   logic ee_last = 1'b1;
   logic clk_q   = 1'b1;
   // ------------
   // Pin levels
   // ------------
   // Enabled device bits win, the rest show the strap resistors
   assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & level);
   // Undriven EEPROM line has no pull, so it wanders
   assign ee_d   = ee_oe ? ee_o : (rep_en ? rep_bit : ~ee_last);
   // Open drain: either party pulls low, the pull-up gives 1
   assign md     = ~(pull_low | (md_oe & ~md_o));
   assign mclk   = clk_q;
   // Host clock toggles while running and rests high
   always @(posedge clk) begin
      clk_q   <= clk_run ? ~clk_q : 1'b1;
      ee_last <= ee_d;
   end
endmodule  // board_model
`default_nettype wire

//--- tb/test_strap_gpio_misc_control.sv
// Self-checking testbench of the miscellaneous pin control block
`timescale 1ns/100ps
`default_nettype none
module test_strap_gpio_misc_control;
   // ------------
   // Signals
   // ------------
   typedef struct {logic wr; logic [7:0] ofs; logic [31:0] data;} row_t;
   logic        sys_clk, hreadyout, hresp, ee_clk, ee_d, ee_d_o, ee_d_oe, mclk, md, md_o, md_oe;
   logic        scan_o, scan_oe, scan_pin, pwr_mode, dbg_mode, scan_active;
   logic [31:0] hrdata;
   logic [7:0]  gpio_i, gpio_o, gpio_oe;
   logic [4:0]  dbg_sel;
   logic [2:0]  mgmt_addr, port_status;
   logic        rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pwr_strap = 1'b1, dbg_n = 1'b1, stat_en = 1'b0;
   logic        mfg_test = 1'b0, scan_i = 1'b0, clk_run = 1'b0, pull_low = 1'b0, rep_en = 1'b0, rep_bit = 1'b0;
   logic        ce = 1'b1;
   logic [2:0]  sz = 3'b010;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010, port_cond = 3'b110;
   logic [7:0]  level = 8'hA5;
   int          err_count = 0, total_checks = 0;
   row_t        rows [12] = '{'{1'b1, 8'h00, 32'h0000_003C}, '{1'b1, 8'h04, 32'h0000_000F},
      '{1'b0, 8'h04, 32'h0000_000F}, '{1'b0, 8'h00, 32'h0000_003C}, '{1'b1, 8'h1C, 32'h1234_5678},
      '{1'b0, 8'h1C, 32'h0000_0000}, '{1'b0, 8'h08, 32'h0000_00AC}, '{1'b1, 8'h10, 32'h0000_0005},
      '{1'b0, 8'h10, 32'h0000_0005}, '{1'b1, 8'h14, 32'h0000_0001}, '{1'b0, 8'h18, 32'h0000_0006},
      '{1'b0, 8'h14, 32'h0000_0003}};
   // Scan pin wire: device drive or the tester level
   assign scan_pin = scan_oe ? scan_o : scan_i;
   strap_gpio_misc_control i_dut (
      .SYS_CLK(sys_clk), .RSTN(rstn), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
      .GPIO_I(gpio_i), .GPIO_O(gpio_o), .GPIO_OE(gpio_oe), .EEPROM_SERIAL_CLOCK(ee_clk),
      .EEPROM_SERIAL_DATA_I(ee_d), .EEPROM_SERIAL_DATA_O(ee_d_o), .EEPROM_SERIAL_DATA_OE(ee_d_oe),
      .MGMT_BUS_CLOCK_PIN(mclk), .MGMT_BUS_DATA_PIN_I(md), .MGMT_BUS_DATA_PIN_O(md_o),
      .MGMT_BUS_DATA_PIN_OE(md_oe), .POWER_SAVING_STRAP(pwr_strap), .DEBUG_MODE_ENABLE_STRAP_N(dbg_n),
      .PORT_STATUS_OUTPUT_ENABLE(stat_en), .MFG_TEST_MODE(mfg_test), .FULL_SCAN_I(scan_pin), .FULL_SCAN_O(scan_o),
      .FULL_SCAN_OE(scan_oe), .PORT_COND(port_cond), .PORT_STATUS(port_status), .POWER_SAVE_MODE(pwr_mode),
      .DEBUG_MODE(dbg_mode), .DEBUG_SELECT(dbg_sel), .MGMT_ADDR(mgmt_addr), .SCAN_ACTIVE(scan_active));
   board_model i_board (
      .clk(sys_clk), .level(level), .clk_run(clk_run), .pull_low(pull_low), .rep_en(rep_en), .rep_bit(rep_bit),
      .gpio_o(gpio_o), .gpio_oe(gpio_oe), .ee_o(ee_d_o), .ee_oe(ee_d_oe), .md_o(md_o), .md_oe(md_oe),
      .gpio_i(gpio_i), .ee_d(ee_d), .mclk(mclk), .md(md));
   // ------------
   // Tasks
   // ------------
   // Verdict and end of run
   task automatic complete_run();
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Compare one value
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // Wait cycles, then let the edge settle
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Bounded wait for bus ready at a rising edge
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         err_count++;
         complete_run();
      end
   endtask
   // One single transfer of size sz: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, ofs};
      hwrite <= wr;
      hsize  <= sz;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   // Read a register and compare it
   task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
      logic [31:0] v;
      ahb(1'b0, ofs, 32'h0000_0000, v);
      chk($sformatf("reg %h", ofs), exp, v);
   endtask
   // Reset with given straps, checking pin levels while held
   task automatic do_reset(input logic p, input logic dn, input logic [7:0] lv);
      @(posedge sys_clk);
      rstn      <= 1'b0;
      pwr_strap <= p;
      dbg_n     <= dn;
      level     <= lv;
      repeat (20) @(posedge sys_clk);
      #1;
      chk("gpio oe", 32'h0, {24'h0, gpio_oe});
      chk("eeprom data", 32'h3, {30'h0, ee_d_o, ee_d_oe});
      chk("scan pin", 32'h2, {30'h0, scan_oe, scan_o});
      @(posedge sys_clk);
      rstn <= 1'b1;
      cyc(6);
   endtask
   // ------------
   // Sequence
   // ------------
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      complete_run();
   end
   // Main scenarios
   initial begin
      logic [31:0] v;
      do_reset(1'b1, 1'b1, 8'hA5);
      chk("straps", 32'h15, {27'h0, pwr_mode, dbg_mode, mgmt_addr});
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            ahb(1'b1, rows[i].ofs, rows[i].data, v);
            cyc(3);  // Let synchronised pin levels settle
         end else begin
            rd_chk(rows[i].ofs, rows[i].data);
         end
      end
      chk("gpio pins", 32'h0F3C, {16'h0, gpio_oe, gpio_o});
      chk("eeprom pins", 32'h5, {29'h0, ee_clk, ee_d_o, ee_d_oe});
      chk("mgmt data", 32'h2, {30'h0, md_oe, md});
      chk("bus response", 32'h0, {31'h0, hresp});
      // A byte-sized write must be ignored
      sz <= 3'b000;
      ahb(1'b1, 8'h00, 32'h0000_00FF, v);
      sz <= 3'b010;
      rd_chk(8'h00, 32'h0000_003C);
      // EEPROM answers on the released line, then idle returns
      ahb(1'b1, 8'h10, 32'h0000_000C, v);
      rep_en  <= 1'b1;
      rep_bit <= 1'b1;
      cyc(4);
      rd_chk(8'h10, 32'h0000_001C);
      ahb(1'b1, 8'h10, 32'h0000_0000, v);
      rep_en <= 1'b0;
      cyc(1);
      chk("eeprom idle", 32'h3, {30'h0, ee_d_o, ee_d_oe});
      // Host clocks and pulls data low
      ahb(1'b1, 8'h14, 32'h0000_0000, v);
      pull_low <= 1'b1;
      clk_run  <= 1'b1;
      cyc(4);
      ahb(1'b0, 8'h14, 32'h0000_0000, v);
      chk("mgmt data in", 32'h0, {31'h0, v[2]});
      pull_low <= 1'b0;
      clk_run  <= 1'b0;
      // Manufacturing test releases the scan pin
      mfg_test <= 1'b1;
      scan_i   <= 1'b1;
      cyc(8);
      chk("scan test", 32'h1, {30'h0, scan_oe, scan_active});
      @(posedge sys_clk);
      mfg_test <= 1'b0;
      cyc(8);
      chk("scan normal", 32'h2, {30'h0, scan_oe, scan_o});
      // Second reset into debug mode, then strap changes must not leak
      do_reset(1'b0, 1'b0, 8'h53);
      chk("straps", 32'h153, {22'h0, pwr_mode, dbg_mode, mgmt_addr, dbg_sel});
      rd_chk(8'h0C, 32'h0000_066A);
      @(posedge sys_clk);
      level     <= 8'h00;
      pwr_strap <= 1'b1;
      dbg_n     <= 1'b1;
      cyc(6);
      chk("held straps", 32'h153, {22'h0, pwr_mode, dbg_mode, mgmt_addr, dbg_sel});
      ahb(1'b1, 8'h04, 32'h0000_00FF, v);
      cyc(1);
      chk("gpio oe debug", 32'hE0, {24'h0, gpio_oe});
      // Port status gated by its enable in debug mode
      @(posedge sys_clk);
      port_cond <= 3'b101;
      cyc(6);
      chk("port status off", 32'h0, {29'h0, port_status});
      @(posedge sys_clk);
      stat_en <= 1'b1;
      cyc(6);
      chk("port status on", 32'h5, {29'h0, port_status});
      // Clock enable low freezes the status register
      @(posedge sys_clk);
      ce        <= 1'b0;
      port_cond <= 3'b010;
      cyc(4);
      chk("port status frozen", 32'h5, {29'h0, port_status});
      @(posedge sys_clk);
      ce <= 1'b1;
      cyc(2);
      chk("port status resumed", 32'h2, {29'h0, port_status});
      complete_run();
   end
endmodule  // test_strap_gpio_misc_control
`default_nettype wire
